// [logic/vseq_pkg.sv]
// package for the vector sequencer: opcodes, end modes, field layout, timing
// assumes a single vector clock domain; no register bus, all control is ports
package vseq_pkg;

  // primary instruction codes
  localparam logic [3:0] OP_NONE       = 4'h0;
  localparam logic [3:0] OP_END_UNCOND = 4'h1;
  localparam logic [3:0] OP_END_EQ     = 4'h2;
  localparam logic [3:0] OP_END_NE     = 4'h3;
  localparam logic [3:0] OP_END_IMM    = 4'h4;
  localparam logic [3:0] OP_WAIT_EQ    = 4'h5;
  localparam logic [3:0] OP_WAIT_NE    = 4'h6;
  localparam logic [3:0] OP_WAIT_EXT1  = 4'h7;
  localparam logic [3:0] OP_WAIT_EXT2  = 4'h8;
  localparam logic [3:0] OP_DELAY_C1   = 4'h9;
  localparam logic [3:0] OP_DELAY_C2   = 4'ha;
  localparam logic [3:0] OP_JUMP       = 4'hb;
  localparam logic [3:0] OP_JUMP_EQ    = 4'hc;
  localparam logic [3:0] OP_JUMP_NE    = 4'hd;
  localparam logic [3:0] OP_JUMP_EXT   = 4'he;

  // end modes for conditional END
  localparam logic [1:0] ENDM_STOP  = 2'h0;
  localparam logic [1:0] ENDM_LOCK  = 2'h1;
  localparam logic [1:0] ENDM_CYCLE = 2'h2;

  // instruction word fields
  localparam int OP_W      = 4;
  localparam int ENDM_W    = 2;
  localparam int EXTSEL_W  = 3;
  localparam int EXTCH_LO  = 16;   // first receiver channel usable as external input
  localparam int EXTCH_N   = 8;    // channels 16..23

  // vector clock
  localparam int CLK_HZ    = 20_000_000;
  localparam int CLK_NS    = 50;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10,
    ST_LOCK = 2'b11
  } seq_state_t;

endpackage

// [logic/vector_sequencer.sv]
// vector sequencer: steps the vector address counter and executes END, WAIT,
// DELAY and JUMP primary instructions fetched from instruction memory.
// assumes the instruction memory answers combinationally for the current address
// and that boards are joined by the cable signals equal_bus and jump_bus.
//
// Operation
// - four primary classes: END, WAIT, DELAY, JUMP
// - unconditional/immediate END stops, address stays put
// - END on Equal/Unequal follows flag, flag readable
// - stop, lock, cycle modes only conditional END
// - master shows timing generator running or stopped
// - WAIT on Equal/Unequal holds address per flag
// - external WAIT uses selected channel 16-23
// - no vector data clocked out while waiting
// - on awaited level, resume past WAIT location
// - DELAY holds address for loaded clock count
// - DELAY uses utility counter load and run
// - unconditional JUMP always loads target address
// - JUMP on Equal/Unequal branches on flag condition
// - JUMP on External branches on selected channel level
// - jump and equal signals shared over cable
// - unconditional END stops all boards that are running or locked (not in DELAY hold), each reports address
// - any board's compare holds or releases all boards
// - two external waits, each with own polarity
// - two delay counters for DELAY instructions
`timescale 1ns/1ps

module vector_sequencer
  import vseq_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int CH_W   = 24,
  parameter int CNT_W  = 32
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // control
  input  wire logic              start_in,
  input  wire logic              is_master_in,
  input  wire logic [1:0]        end_mode_in,
  input  wire logic [ADDR_W-1:0] start_addr_in,
  input  wire logic [EXTSEL_W-1:0] ext_wait1_sel_in,
  input  wire logic              ext_wait1_pol_in,
  input  wire logic [EXTSEL_W-1:0] ext_wait2_sel_in,
  input  wire logic              ext_wait2_pol_in,
  input  wire logic [EXTSEL_W-1:0] ext_jump_sel_in,
  input  wire logic              ext_jump_pol_in,
  input  wire logic [CNT_W-1:0]  delay1_load_in,
  input  wire logic [CNT_W-1:0]  delay2_load_in,
  // instruction memory
  input  wire logic [OP_W-1:0]   instr_op_in,
  input  wire logic [ADDR_W-1:0] instr_target_in,
  // compare path
  input  wire logic [CH_W-1:0]   rx_data_in,
  input  wire logic [CH_W-1:0]   expect_data_in,
  input  wire logic [CH_W-1:0]   cmp_enable_in,
  // interconnect cable, wired-or among boards
  input  wire logic              equal_bus_in,
  input  wire logic              unequal_bus_in,
  input  wire logic              jump_bus_in,
  input  wire logic              end_bus_in,
  // outputs
  output logic [ADDR_W-1:0]      vector_address_counter_out,
  output logic                   vector_clk_en_out,
  output logic                   running_out,
  output logic                   equal_flag_out,
  output logic                   equal_drive_out,
  output logic                   unequal_drive_out,
  output logic                   jump_drive_out,
  output logic                   end_drive_out,
  output logic                   timing_gen_running_status_out,
  output logic                   timing_gen_stopped_status_out
);

  // elaboration check: external channel mux needs channels 16..23
  if (CH_W < EXTCH_LO + EXTCH_N) begin : g_bad_ch
    $error("CH_W too small for external channels");
  end

  // external channel pick, used by three instructions
  function automatic logic ext_level(input logic [CH_W-1:0] d, input logic [EXTSEL_W-1:0] s);
    ext_level = d[EXTCH_LO + int'(s)];
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers (three flops, change accepted when 2 and 3 agree)
  // ------------------------------------------------------------
  logic [EXTCH_N-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_q;
  logic [EXTCH_N-1:0] ext_s1_d, ext_s2_d, ext_s3_d, ext_d;
  logic [2:0]         busa_q, busb_q, busc_q, bus_q;
  logic [2:0]         busa_d, busb_d, busc_d, bus_d;
  logic [CH_W-1:0]    ext_full;

  always_comb begin
    ext_s1_d = rx_data_in[EXTCH_LO +: EXTCH_N];
    ext_s2_d = ext_s1_q;
    ext_s3_d = ext_s2_q;
    busa_d   = {equal_bus_in, unequal_bus_in, jump_bus_in};
    busb_d   = busa_q;
    busc_d   = busb_q;
    ext_d    = ext_q;
    bus_d    = bus_q;
    // accept a bit only once the second and third stages agree (glitch filter)
    for (int i = 0; i < EXTCH_N; i++) begin
      if (ext_s2_q[i] == ext_s3_q[i]) begin
        ext_d[i] = ext_s3_q[i];
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (busb_q[i] == busc_q[i]) begin
        bus_d[i] = busc_q[i];
      end
    end
    ext_full = '0;
    ext_full[EXTCH_LO +: EXTCH_N] = ext_q;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      ext_q    <= '0;
      busa_q   <= '0;
      busb_q   <= '0;
      busc_q   <= '0;
      bus_q    <= '0;
    end else begin
      ext_s1_q <= ext_s1_d;
      ext_s2_q <= ext_s2_d;
      ext_s3_q <= ext_s3_d;
      ext_q    <= ext_d;
      busa_q   <= busa_d;
      busb_q   <= busb_d;
      busc_q   <= busc_d;
      bus_q    <= bus_d;
    end
  end

  // end_bus uses the same three stage scheme
  logic [2:0] endsy_q, endsy_d;
  logic       end_seen_q, end_seen_d;
  always_comb begin
    endsy_d    = {endsy_q[1:0], end_bus_in};
    end_seen_d = end_seen_q;
    if (endsy_q[1] == endsy_q[2]) begin
      end_seen_d = endsy_q[2];
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      endsy_q    <= '0;
      end_seen_q <= 1'b0;
    end else begin
      endsy_q    <= endsy_d;
      end_seen_q <= end_seen_d;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  seq_state_t        state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [CNT_W-1:0]  dcnt_q, dcnt_d;
  logic              eq_q, eq_d, clken_q, clken_d;
  logic              eqdrv_q, eqdrv_d, nedrv_q, nedrv_d, jdrv_q, jdrv_d, edrv_q, edrv_d;
  logic              timing_gen_running_status_q, timing_gen_running_status_d, timing_gen_stopped_status_q, timing_gen_stopped_status_d;
  logic              run_q, run_d;
  logic              local_eq, sys_eq, sys_ne, wait_go, take_jump, is_cond_end, end_hit;

  always_comb begin
    // local compare on enabled channels; shared so all boards decide alike
    local_eq    = ((rx_data_in ^ expect_data_in) & cmp_enable_in) == '0;
    // any board unequal clears equality everywhere
    sys_eq      = eq_q && !bus_q[1];
    sys_ne      = !eq_q || bus_q[1];
    wait_go     = 1'b1;
    take_jump   = 1'b0;
    is_cond_end = (instr_op_in == OP_END_EQ) || (instr_op_in == OP_END_NE);
    end_hit     = 1'b0;
    state_d  = state_q;
    addr_d   = addr_q;
    dcnt_d   = dcnt_q;
    eq_d     = eq_q;
    clken_d  = 1'b0;
    eqdrv_d  = eqdrv_q;
    nedrv_d  = nedrv_q;
    jdrv_d   = 1'b0;
    edrv_d   = 1'b0;
    timing_gen_running_status_d  = timing_gen_running_status_q;
    timing_gen_stopped_status_d = timing_gen_stopped_status_q;

    case (instr_op_in)
      OP_WAIT_EQ:   wait_go = sys_eq;
      OP_WAIT_NE:   wait_go = sys_ne;
      OP_WAIT_EXT1: wait_go = ext_level(ext_full, ext_wait1_sel_in) == ext_wait1_pol_in;
      OP_WAIT_EXT2: wait_go = ext_level(ext_full, ext_wait2_sel_in) == ext_wait2_pol_in;
      OP_JUMP:      take_jump = 1'b1;
      OP_JUMP_EQ:   take_jump = sys_eq;
      OP_JUMP_NE:   take_jump = sys_ne;
      OP_JUMP_EXT:  take_jump = ext_level(ext_full, ext_jump_sel_in) == ext_jump_pol_in;
      OP_END_UNCOND, OP_END_IMM: end_hit = 1'b1;
      OP_END_EQ:    end_hit = sys_eq;
      OP_END_NE:    end_hit = sys_ne;
      default:      wait_go = 1'b1;
    endcase

    case (state_q)
      ST_IDLE: begin
        if (start_in) begin
          state_d  = ST_RUN;
          addr_d   = start_addr_in;
          timing_gen_running_status_d  = 1'b1;
          timing_gen_stopped_status_d = 1'b0;
          eqdrv_d  = 1'b0;
          nedrv_d  = 1'b0;
        end
      end
      ST_RUN: begin
        // flag updated each vector; stays put after the run ends
        eq_d    = local_eq;
        eqdrv_d = local_eq;
        nedrv_d = !local_eq;
        if (end_seen_q) begin
          // another board ended unconditionally: stop here too
          state_d  = ST_IDLE;
          timing_gen_running_status_d  = 1'b0;
          timing_gen_stopped_status_d = 1'b1;
        end else if (end_hit) begin
          // address counter left on the END location, except cycle mode reloads the start address
          edrv_d = (instr_op_in == OP_END_UNCOND);
          if (is_cond_end && end_mode_in == ENDM_LOCK) begin
            state_d = ST_LOCK;
          end else if (is_cond_end && end_mode_in == ENDM_CYCLE) begin
            addr_d  = start_addr_in;
            clken_d = 1'b1;
          end else begin
            state_d  = ST_IDLE;
            timing_gen_running_status_d  = 1'b0;
            timing_gen_stopped_status_d = 1'b1;
          end
        end else if (!wait_go) begin
          clken_d = 1'b0;
        end else if (instr_op_in == OP_DELAY_C1 || instr_op_in == OP_DELAY_C2) begin
          // utility counter load for the selected delay counter
          dcnt_d  = (instr_op_in == OP_DELAY_C1) ? delay1_load_in : delay2_load_in;
          state_d = ST_HOLD;
        end else begin
          clken_d = 1'b1;
          jdrv_d  = take_jump;
          addr_d  = (take_jump || bus_q[0]) ? instr_target_in : addr_q + 1'b1;
        end
      end
      ST_HOLD: begin
        // one decrement per vector clock, move on at zero
        if (dcnt_q == '0) begin
          state_d = ST_RUN;
          addr_d  = addr_q + 1'b1;
          clken_d = 1'b1;
        end else begin
          dcnt_d = dcnt_q - 1'b1;
        end
      end
      ST_LOCK: begin
        // timing generator keeps running but the pattern is frozen
        timing_gen_running_status_d  = 1'b1;
        timing_gen_stopped_status_d = 1'b0;
        if (end_seen_q) begin
          // a cable end releases the lock and reports the generator stopped
          state_d  = ST_IDLE;
          timing_gen_running_status_d  = 1'b0;
          timing_gen_stopped_status_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // only the master reports timing generator status
    if (!is_master_in) begin
      timing_gen_running_status_d  = 1'b0;
      timing_gen_stopped_status_d = 1'b0;
    end
    // running flag kept in its own flop so the port comes straight from a register
    run_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q  <= ST_IDLE;
      addr_q   <= '0;
      dcnt_q   <= '0;
      eq_q     <= 1'b0;
      clken_q  <= 1'b0;
      eqdrv_q  <= 1'b0;
      nedrv_q  <= 1'b0;
      jdrv_q   <= 1'b0;
      edrv_q   <= 1'b0;
      timing_gen_running_status_q  <= 1'b0;
      timing_gen_stopped_status_q <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      addr_q   <= addr_d;
      dcnt_q   <= dcnt_d;
      eq_q     <= eq_d;
      clken_q  <= clken_d;
      eqdrv_q  <= eqdrv_d;
      nedrv_q  <= nedrv_d;
      jdrv_q   <= jdrv_d;
      edrv_q   <= edrv_d;
      timing_gen_running_status_q  <= timing_gen_running_status_d;
      timing_gen_stopped_status_q <= timing_gen_stopped_status_d;
      run_q    <= run_d;
    end
  end

  // outputs straight from flops
  assign vector_address_counter_out    = addr_q;
  assign vector_clk_en_out             = clken_q;
  assign running_out                   = run_q;
  assign equal_flag_out                = eq_q;
  assign equal_drive_out               = eqdrv_q;
  assign unequal_drive_out             = nedrv_q;
  assign jump_drive_out                = jdrv_q;
  assign end_drive_out                 = edrv_q;
  assign timing_gen_running_status_out = timing_gen_running_status_q;
  assign timing_gen_stopped_status_out = timing_gen_stopped_status_q;

endmodule

// [verif/seq_monitor.sv]
// checker on the top ports of the vector sequencer
// assumes one vector clock domain; bound from the bench top file
`timescale 1ns/1ps
module seq_monitor
  import vseq_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              core_clk_in,
  input wire logic              rst_in,
  input wire logic              start_in,
  input wire logic [ADDR_W-1:0] start_addr_in,
  input wire logic [OP_W-1:0]   instr_op_in,
  input wire logic [ADDR_W-1:0] instr_target_in,
  input wire logic [ADDR_W-1:0] vector_address_counter_out,
  input wire logic              vector_clk_en_out,
  input wire logic              running_out,
  input wire logic              equal_flag_out,
  input wire logic              timing_gen_running_status_out,
  input wire logic              timing_gen_stopped_status_out,
  input wire logic              jump_drive_out,
  input wire logic              end_drive_out
);
  // ----------------------------------------
  // flow checks, all on the vector clock
  // ----------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_start_loads_addr:
    assert property (!running_out && start_in |=> running_out && vector_address_counter_out == $past(start_addr_in))
    else $error("start did not load address");
  a_end_stops_run:
    assert property (running_out && (instr_op_in == OP_END_UNCOND || instr_op_in == OP_END_IMM)
      |=> !running_out && $stable(vector_address_counter_out)) else $error("end did not stop in place");
  a_jump_loads_target:
    assert property (running_out && instr_op_in == OP_JUMP |=> vector_address_counter_out == $past(instr_target_in))
    else $error("jump missed target");
  a_plain_advance:
    assert property (running_out && instr_op_in == OP_NONE
      |=> vector_address_counter_out == $past(vector_address_counter_out) + 1'b1 && vector_clk_en_out)
    else $error("plain vector did not advance");
  a_stop_status:
    assert property ($fell(running_out) |-> ##[0:1] (timing_gen_stopped_status_out && !timing_gen_running_status_out))
    else $error("stop status wrong");
  // a held address must not clock vector data out
  a_no_clock_held:
    assert property (running_out && $past(running_out) && $stable(vector_address_counter_out) |-> !vector_clk_en_out)
    else $error("vector clocked while held");
  a_wait_holds_addr:
    assert property (running_out && ((instr_op_in == OP_WAIT_EQ && !equal_flag_out)
      || (instr_op_in == OP_WAIT_NE && equal_flag_out)) |=> $stable(vector_address_counter_out))
    else $error("wait did not hold");
  a_idle_keeps_addr:
    assert property (!running_out && !start_in |=> $stable(vector_address_counter_out))
    else $error("address moved while stopped");
  a_end_pulse_out:
    assert property (running_out && instr_op_in == OP_END_UNCOND |=> end_drive_out)
    else $error("end pulse missing");
  a_jump_pulse_out:
    assert property (running_out && instr_op_in == OP_JUMP |=> jump_drive_out)
    else $error("jump pulse missing");
endmodule

// [verif/board_partner.sv]
// far side model: instruction memory, unit under test channels, one slave board
// assumes the bench fills mem_op while the sequencer sits in reset
`timescale 1ns/1ps
module board_partner
  import vseq_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // sequencer side
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              unequal_drive_in,
  input  wire logic              equal_drive_in,
  // bench controls
  input  wire logic              mis_in,
  input  wire logic              mask_in,
  input  wire logic              slave_uneq_in,
  input  wire logic [7:0]        ext_in,
  // answers
  output logic [OP_W-1:0]        instr_op_out,
  output logic [ADDR_W-1:0]      instr_target_out,
  output logic [23:0]            rx_data_out,
  output logic [23:0]            expect_data_out,
  output logic [23:0]            cmp_enable_out,
  output logic                   equal_bus_out,
  output logic                   unequal_bus_out
);
  // ----------------------------------------
  // memory, channels and cable
  // ----------------------------------------
  logic [OP_W-1:0] mem_op [2**ADDR_W];

  // combinational memory, one jump target for every location
  assign instr_op_out     = mem_op[addr_in];
  assign instr_target_out = ADDR_W'('h14);
  // upper channels carry the external levels and are left out of the compare
  assign expect_data_out  = 24'h00a5c3;
  assign rx_data_out      = {ext_in, 16'ha5c3 ^ {15'h0000, mis_in}};
  assign cmp_enable_out   = {8'h00, 15'h7fff, ~mask_in};
  // wired-or cable: the slave can force unequal for every board
  assign unequal_bus_out  = unequal_drive_in | slave_uneq_in;
  assign equal_bus_out    = equal_drive_in;
endmodule

// [verif/tb.sv]
// bench for the vector sequencer: short programs, checked by where they stop
// assumes the partner model supplies memory, channels and a slave board
`timescale 1ns/1ps
module tb;
  import vseq_pkg::*;
  localparam int ADDR_W = 6;
  logic              clk        = 1'b0;
  logic              rst        = 1'b1;
  logic              start      = 1'b0;
  logic [1:0]        end_mode   = ENDM_STOP;
  logic [7:0]        load       = 8'h03;
  logic [7:0]        ext        = 8'h00;
  logic [2:0]        sel        = 3'h0;
  logic              pol        = 1'b0;
  logic              mis        = 1'b0;
  logic              mask       = 1'b0;
  logic              slave_uneq = 1'b0;
  logic              slave_end  = 1'b0;
  logic              e;
  logic [ADDR_W-1:0] addr, tgt;
  logic [OP_W-1:0]   op;
  logic [23:0]       rx, expd, cen;
  logic              clk_en, running, eq_flag, eq_drv, ne_drv, eq_bus, ne_bus, tg_run, tg_stop;
  int                err_total   = 0;
  int                check_count = 0;
  int                n;
  logic [3:0]        wops [5]    = '{OP_WAIT_EQ, OP_WAIT_NE, OP_WAIT_EXT1, OP_WAIT_EXT2, OP_WAIT_EQ};
  logic [3:0]        cops [4]    = '{OP_END_EQ, OP_END_NE, OP_JUMP_EQ, OP_JUMP_NE};

  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  always #25 clk = ~clk;

  vector_sequencer #(.ADDR_W(ADDR_W), .CH_W(24), .CNT_W(8)) dut (
    .core_clk_in(clk), .rst_in(rst), .start_in(start), .is_master_in(1'b1), .end_mode_in(end_mode),
    .start_addr_in(6'h02), .ext_wait1_sel_in(sel), .ext_wait1_pol_in(pol), .ext_wait2_sel_in(sel),
    .ext_wait2_pol_in(pol), .ext_jump_sel_in(sel), .ext_jump_pol_in(pol), .delay1_load_in(load),
    .delay2_load_in(load), .instr_op_in(op), .instr_target_in(tgt), .rx_data_in(rx), .expect_data_in(expd),
    .cmp_enable_in(cen), .equal_bus_in(eq_bus), .unequal_bus_in(ne_bus), .jump_bus_in(1'b0),
    .end_bus_in(slave_end), .vector_address_counter_out(addr), .vector_clk_en_out(clk_en), .running_out(running),
    .equal_flag_out(eq_flag), .equal_drive_out(eq_drv), .unequal_drive_out(ne_drv), .jump_drive_out(),
    .end_drive_out(), .timing_gen_running_status_out(tg_run), .timing_gen_stopped_status_out(tg_stop));

  board_partner #(.ADDR_W(ADDR_W)) pm (
    .addr_in(addr), .unequal_drive_in(ne_drv), .equal_drive_in(eq_drv), .mis_in(mis), .mask_in(mask),
    .slave_uneq_in(slave_uneq), .ext_in(ext), .instr_op_out(op), .instr_target_out(tgt), .rx_data_out(rx),
    .expect_data_out(expd), .cmp_enable_out(cen), .equal_bus_out(eq_bus), .unequal_bus_out(ne_bus));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // program: code under test at 8, stops at 9 and at the jump target
  task automatic launch(input logic [3:0] code);
    rst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      pm.mem_op[i] = (i == 9 || i == 20) ? OP_END_UNCOND : OP_NONE;
    end
    pm.mem_op[8] = code;
    rst <= 1'b0;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  // sampled on the falling edge so the stop has settled
  task automatic finish_at(input logic [7:0] exp);
    repeat (300) begin
      @(negedge clk);
      if (running === 1'b0) break;
    end
    chk(8'(running), 8'h00);
    chk(8'(addr), exp);
    @(posedge clk);
  endtask

  task automatic finish_test();
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    launch(OP_END_UNCOND);
    finish_at(8'h08);
    chk(8'({tg_run, tg_stop}), 8'h01);
    launch(OP_END_IMM);
    finish_at(8'h08);
    for (int k = 0; k < 12; k++) begin
      mis <= (k > 3);
      mask <= (k > 7);
      e = (k < 4 || k > 7);
      launch(cops[k % 4]);
      finish_at((e ^ k[0]) ? ((k % 4 < 2) ? 8'h08 : 8'h14) : 8'h09);
      chk(8'(eq_flag), 8'(e));
    end
    end_mode <= ENDM_LOCK;
    launch(OP_END_EQ);
    repeat (20) @(posedge clk);
    chk(8'(addr), 8'h08);
    chk(8'({running, tg_run}), 8'h03);
    // a slave board ending over the cable releases the lock
    slave_end <= 1'b1;
    finish_at(8'h08);
    chk(8'({tg_run, tg_stop}), 8'h01);
    slave_end <= 1'b0;
    // lock mode is ignored by an unconditional END
    launch(OP_END_UNCOND);
    finish_at(8'h08);
    end_mode <= ENDM_CYCLE;
    launch(OP_END_EQ);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += (addr === 6'h02);
    end
    chk(8'(n > 2), 8'h01);
    end_mode <= ENDM_STOP;
    mask <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      sel <= 3'(k + 1);
      pol <= k[0];
      ext <= {8{~k[0]}};
      mis <= (k == 0);
      slave_uneq <= (k == 4);
      launch(wops[k]);
      repeat (20) @(posedge clk);
      chk(8'(addr), 8'h08);
      chk(8'(clk_en), 8'h00);
      mis <= (k == 1);
      ext <= ext ^ (8'h01 << (k + 1));
      slave_uneq <= 1'b0;
      finish_at(8'h09);
    end
    for (int k = 0; k < 4; k++) begin
      load <= 8'(3 + 2 * k);
      launch(k[0] ? OP_DELAY_C2 : OP_DELAY_C1);
      n = 0;
      repeat (40) begin
        @(negedge clk);
        n += (addr === 6'h08);
      end
      chk(8'(n == 4 + 2 * k || n == 5 + 2 * k), 8'h01);
    end
    for (int k = 0; k < 3; k++) begin
      sel <= 3'h7;
      pol <= (k < 2);
      ext <= 8'h80;
      launch(k > 0 ? OP_JUMP_EXT : OP_JUMP);
      finish_at(k == 2 ? 8'h09 : 8'h14);
    end
    finish_test();
  end

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule

bind vector_sequencer seq_monitor #(.ADDR_W(ADDR_W)) mon (
  .core_clk_in, .rst_in, .start_in, .start_addr_in, .instr_op_in, .instr_target_in,
  .vector_address_counter_out, .vector_clk_en_out, .running_out, .equal_flag_out,
  .timing_gen_running_status_out, .timing_gen_stopped_status_out, .jump_drive_out, .end_drive_out);
